// >>> dlp_defs.vh
// Register indices, field positions, reset values and mode codes for dlp.
`ifndef DLP_DEFS_VH
`define DLP_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DLP_IDX_FACTOR    8'h01
`define DLP_IDX_CTRL      8'h02
`define DLP_IDX_SYNC      8'h05
`define DLP_IDX_STATUS    8'h10
`define DLP_IDX_SAMPLE_LO 8'h11
`define DLP_IDX_SAMPLE_HI 8'h12

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DLP_CTRL_POL_BIT      4
`define DLP_CTRL_DCOE_BIT     3
`define DLP_CTRL_REC_BIT      2
`define DLP_SYNC_OFS_MSB      7
`define DLP_SYNC_OFS_LSB      4
`define DLP_SYNC_MODULATOR_SYNC_SELECT_BIT  3
`define DLP_FACTOR_MSB        1
`define DLP_FACTOR_LSB        0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DLP_RST_OFFSET   4'h0
`define DLP_RST_FACTOR   2'h0
`define DLP_RST_BIT      1'b0

// ----------------------------------------------------------------------
// Interpolation factor codes
// ----------------------------------------------------------------------
`define DLP_FAC_1X 2'h0
`define DLP_FAC_2X 2'h1
`define DLP_FAC_4X 2'h2
`define DLP_FAC_8X 2'h3

// ----------------------------------------------------------------------
// Capture mode codes shown in the status register
// ----------------------------------------------------------------------
`define DLP_MODE_MASTER   3'h0
`define DLP_MODE_EXTSYNC  3'h1
`define DLP_MODE_SLAVE    3'h2
`define DLP_MODE_LOWSH    3'h3
`define DLP_MODE_MODSLAVE 3'h4

`endif

// >>> dlp_sync2.v
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/10ps
module dlp_sync2 #(
    parameter WIDTH = 1
) (
    input wire clk,                // Conversion clock
    input wire arst_n,             // Asynchronous reset, active low
    input wire [WIDTH-1:0] d,      // Raw pin levels
    output wire [WIDTH-1:0] q      // Synchronised levels
);

    genvar i;

    // ------------------------------------------------------------------
    // One two-flop chain per bit; only stage2 reads stage1
    // ------------------------------------------------------------------
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= d[i];
                    stage2 <= stage1;
                end
            end
            assign q[i] = stage2;
        end
    endgenerate

endmodule

// >>> dlp_factor_select_a.v
// Linear interpolator giving one output code per conversion clock cycle.
`timescale 1ns/10ps
`include "dlp_defs.vh"
module dlp_factor_select_a #(
    parameter W = 16
) (
    input wire clk,                // Conversion clock
    input wire arst_n,             // Asynchronous reset, active low
    input wire load,               // New captured sample, one-cycle pulse
    input wire [W-1:0] sample,     // Captured sample
    input wire [1:0] factor_sel,   // Interpolation factor code
    output reg [W-1:0] dac_code    // Output code, one per cycle
);

    reg [W-1:0] prev;
    reg [W-1:0] cur;
    reg [2:0] step;
    reg [W:0] diff;
    reg [W+3:0] prod;
    reg [W+3:0] part;
    reg [W-1:0] next_dac_code;

    // ------------------------------------------------------------------
    // Point between the last two samples, weighted by the step count
    // ------------------------------------------------------------------
    always @* begin
        diff = {cur[W-1], cur} - {prev[W-1], prev};
        prod = $signed({{3{diff[W]}}, diff}) * $signed({1'b0, step});
        case (factor_sel)
            `DLP_FAC_2X: part = $signed(prod) >>> 1;
            `DLP_FAC_4X: part = $signed(prod) >>> 2;
            `DLP_FAC_8X: part = $signed(prod) >>> 3;
            default:     part = {(W+4){1'b0}};
        endcase
        if (factor_sel == `DLP_FAC_1X) begin
            next_dac_code = cur;
        end else begin
            next_dac_code = prev + part[W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Sample history and step counter, restarting on each load
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= {W{1'b0}};
            cur <= {W{1'b0}};
            step <= 3'h0;
            dac_code <= {W{1'b0}};
        end else begin
            dac_code <= next_dac_code;
            if (load) begin
                prev <= cur;
                cur <= sample;
                step <= 3'h0;
            end else if (step != 3'h7) begin
                step <= step + 3'h1;
            end
        end
    end

endmodule

// >>> dlp_data_port.v
// Parallel sample port: capture-edge control, mode select and registers.
`timescale 1ns/10ps
`include "dlp_defs.vh"
module dlp_data_port #(
    parameter W = 16
) (
    input wire clk,                     // Conversion clock, 50 MHz
    input wire arst_n,                  // Asynchronous reset, active low
    input wire [7:0] bus_addr,          // Register byte address
    input wire [7:0] bus_wdata,         // Register write data
    input wire bus_we,                  // Write strobe
    input wire bus_re,                  // Read strobe
    output reg [7:0] bus_rdata,         // Read data, cycle after strobe
    input wire data_rate_clock_in,      // Data-rate clock pin level
    output reg data_rate_clock_out,     // Generated data-rate clock
    output reg data_rate_clock_oe,      // High while driving the pin
    input wire [W-1:0] sample_in,       // Parallel sample pins
    output reg [W-1:0] sample_out,      // Last captured sample
    output reg sample_strobe,           // Capture pulse, one cycle
    output reg [W-1:0] dac_code         // Interpolated code per cycle
);

    // ------------------------------------------------------------------
    // Control registers and local state
    // ------------------------------------------------------------------
    reg latch_edge_polarity;
    reg data_clock_output_enable;
    reg data_recovery_enable;
    reg modulator_sync_select;
    reg [3:0] latch_edge_offset;
    reg [1:0] factor_select_a;
    reg [2:0] cnt;
    reg pin_clk_d;
    reg toggle_1x;
    reg [2:0] mode;
    reg [2:0] mask;
    reg [2:0] half;
    reg [2:0] shift;
    reg [2:0] phase;
    reg [2:0] next_phase;
    reg [2:0] next_cnt;
    reg capture;
    reg next_clk_out;
    reg [7:0] next_rdata;
    wire [W:0] sync_q;
    wire pin_clk;
    wire [W-1:0] pin_data;
    wire [W-1:0] factor_select_a_code;
    wire [5:0] idx;
    wire aligned;

    assign idx = bus_addr[7:2];
    assign aligned = (bus_addr[1:0] == 2'h0);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Factor code to period mask (period length minus one)
    function [2:0] fac_mask;
        input [1:0] sel;
        begin
            case (sel)
                `DLP_FAC_2X: fac_mask = 3'h1;
                `DLP_FAC_4X: fac_mask = 3'h3;
                `DLP_FAC_8X: fac_mask = 3'h7;
                default:     fac_mask = 3'h0;
            endcase
        end
    endfunction

    // Signed offset code scaled to the factor, modulo the period
    function [2:0] ofs_shift;
        input [3:0] code;
        input [1:0] sel;
        begin
            case (sel)
                `DLP_FAC_8X: ofs_shift = code[2:0];
                `DLP_FAC_4X: ofs_shift = {1'b0, code[2:1]};
                `DLP_FAC_2X: ofs_shift = {2'h0, code[2]};
                default:     ofs_shift = 3'h0;
            endcase
        end
    endfunction

    // Register index match for an aligned access
    function hit;
        input [5:0] a;
        input [7:0] want;
        begin
            hit = (a == want[5:0]);
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers: clock pin and sample pins share one delay
    // ------------------------------------------------------------------
    dlp_sync2 #(
        .WIDTH(W + 1)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({data_rate_clock_in, sample_in}),
        .q(sync_q)
    );

    assign pin_clk = sync_q[W];
    assign pin_data = sync_q[W-1:0];

    // ------------------------------------------------------------------
    // Mode decode from output enable, modulator sync and recovery bits
    // ------------------------------------------------------------------
    always @* begin
        if (data_clock_output_enable) begin
            mode = `DLP_MODE_MASTER;
        end else begin
            case ({modulator_sync_select, data_recovery_enable})
                2'b00:   mode = `DLP_MODE_EXTSYNC;
                2'b01:   mode = `DLP_MODE_SLAVE;
                2'b10:   mode = `DLP_MODE_LOWSH;
                default: mode = `DLP_MODE_MODSLAVE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Phase arithmetic and capture-edge selection
    // ------------------------------------------------------------------
    always @* begin
        mask = fac_mask(factor_select_a);
        half = (mask >> 1) + 3'h1;                        // No wrap at 8x
        next_cnt = (cnt + 3'h1) & mask;
        if (mode == `DLP_MODE_MASTER) begin
            shift = ofs_shift(latch_edge_offset, factor_select_a);
        end else begin
            shift = 3'h0;
        end
        phase = (cnt - shift) & mask;
        next_phase = (next_cnt - shift) & mask;
        capture = 1'b0;
        case (mode)
            `DLP_MODE_MASTER,
            `DLP_MODE_EXTSYNC: begin
                if (mask == 3'h0) begin
                    capture = 1'b1;
                end else if (latch_edge_polarity) begin
                    capture = (phase == mask);
                end else begin
                    capture = (phase == half - 3'h1);
                end
            end
            default: begin
                if (latch_edge_polarity) begin
                    capture = pin_clk & ~pin_clk_d;
                end else begin
                    capture = ~pin_clk & pin_clk_d;
                end
            end
        endcase
        // Generated clock rises right after the polarity-1 capture edge
        if (mask == 3'h0) begin
            next_clk_out = ~toggle_1x;
        end else begin
            next_clk_out = (next_phase < half);
        end
    end

    // ------------------------------------------------------------------
    // Phase counter, pin edge history and generated clock pin
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 3'h0;
            pin_clk_d <= 1'b0;
            toggle_1x <= 1'b0;
            data_rate_clock_out <= 1'b0;
            data_rate_clock_oe <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pin_clk_d <= pin_clk;
            toggle_1x <= ~toggle_1x;
            if (mode == `DLP_MODE_MASTER) begin
                data_rate_clock_out <= next_clk_out;
                data_rate_clock_oe <= 1'b1;
            end else begin
                data_rate_clock_out <= 1'b0;
                data_rate_clock_oe <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sample capture on the selected edge
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_out <= {W{1'b0}};
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= capture;
            if (capture) begin
                sample_out <= pin_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interpolator fed by captured samples
    // ------------------------------------------------------------------
    dlp_factor_select_a #(
        .W(W)
    ) u_factor_select_a (
        .clk(clk),
        .arst_n(arst_n),
        .load(sample_strobe),
        .sample(sample_out),
        .factor_sel(factor_select_a),
        .dac_code(factor_select_a_code)
    );

    // Output code registered once more so the port leaves a flop
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_code <= {W{1'b0}};
        end else begin
            dac_code <= factor_select_a_code;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_edge_polarity <= `DLP_RST_BIT;
            data_clock_output_enable <= `DLP_RST_BIT;
            data_recovery_enable <= `DLP_RST_BIT;
            modulator_sync_select <= `DLP_RST_BIT;
            latch_edge_offset <= `DLP_RST_OFFSET;
            factor_select_a <= `DLP_RST_FACTOR;
        end else if (bus_we && aligned) begin
            if (hit(idx, `DLP_IDX_CTRL)) begin
                latch_edge_polarity <=
                    bus_wdata[`DLP_CTRL_POL_BIT];
                data_clock_output_enable <=
                    bus_wdata[`DLP_CTRL_DCOE_BIT];
                data_recovery_enable <=
                    bus_wdata[`DLP_CTRL_REC_BIT];
            end
            if (hit(idx, `DLP_IDX_SYNC)) begin
                latch_edge_offset <=
                    bus_wdata[`DLP_SYNC_OFS_MSB:`DLP_SYNC_OFS_LSB];
                modulator_sync_select <=
                    bus_wdata[`DLP_SYNC_MODULATOR_SYNC_SELECT_BIT];
            end
            if (hit(idx, `DLP_IDX_FACTOR)) begin
                factor_select_a <=
                    bus_wdata[`DLP_FACTOR_MSB:`DLP_FACTOR_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read mux; unmapped or unaligned reads return zero
    // ------------------------------------------------------------------
    always @* begin
        next_rdata = 8'h00;
        if (aligned) begin
            if (hit(idx, `DLP_IDX_CTRL)) begin
                next_rdata[`DLP_CTRL_POL_BIT] = latch_edge_polarity;
                next_rdata[`DLP_CTRL_DCOE_BIT] = data_clock_output_enable;
                next_rdata[`DLP_CTRL_REC_BIT] = data_recovery_enable;
            end else if (hit(idx, `DLP_IDX_SYNC)) begin
                next_rdata[`DLP_SYNC_OFS_MSB:`DLP_SYNC_OFS_LSB] =
                    latch_edge_offset;
                next_rdata[`DLP_SYNC_MODULATOR_SYNC_SELECT_BIT] = modulator_sync_select;
            end else if (hit(idx, `DLP_IDX_FACTOR)) begin
                next_rdata[`DLP_FACTOR_MSB:`DLP_FACTOR_LSB] =
                    factor_select_a;
            end else if (hit(idx, `DLP_IDX_STATUS)) begin
                next_rdata = {mode, factor_select_a, phase};
            end else if (hit(idx, `DLP_IDX_SAMPLE_LO)) begin
                next_rdata = sample_out[7:0];
            end else if (hit(idx, `DLP_IDX_SAMPLE_HI)) begin
                next_rdata = sample_out[W-1:W-8];
            end
        end
    end

    // Read data stand for one cycle after the strobe, zero otherwise
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= 8'h00;
        end else if (bus_re) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= 8'h00;
        end
    end

endmodule

// >>> dlp_port_props.sv
// Property checker for the sample port, bound to its top module.
`timescale 1ns/10ps
module dlp_port_props #(
    parameter W = 16
) (
    input wire clk, // Conversion clock
    input wire arst_n, // Reset, active low
    input wire [7:0] bus_addr, // Byte address
    input wire [7:0] bus_wdata, // Write data
    input wire bus_we, // Write strobe
    input wire bus_re, // Read strobe
    input wire [7:0] bus_rdata, // Read data
    input wire data_rate_clock_in, // Pin level
    input wire data_rate_clock_out, // Generated clock
    input wire data_rate_clock_oe, // Pin drive
    input wire [W-1:0] sample_in, // Sample pins
    input wire [W-1:0] sample_out, // Captured sample
    input wire sample_strobe, // Capture pulse
    input wire [W-1:0] dac_code // Output code
);
    reg [1:0] fac;
    reg [3:0] ofs;
    reg [3:0] eage;
    reg [4:0] age;
    reg [7:0] gap, oage, rel;
    reg pol, dcoe, rec, msync, pin_q, gok, rok;
    wire setl = (age == 5'h1f);
    wire pinm = !dcoe && msync && !rec;
    wire paced = dcoe || (!msync && !rec);
    wire [7:0] nfac = 8'h01 << fac;
    // Shadow control fields; ages of strobes, clock rises and pin edges
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fac <= 2'h0;
            ofs <= 4'h0;
            {pol, dcoe, rec, msync, pin_q, gok, rok} <= 7'h00;
            age <= 5'h00;
            eage <= 4'h0;
            {gap, oage, rel} <= 24'h000000;
        end else begin
            if (bus_we && bus_addr == 8'h04) fac <= bus_wdata[1:0];
            if (bus_we && bus_addr == 8'h08) begin
                {pol, dcoe, rec} <= bus_wdata[4:2];
            end
            if (bus_we && bus_addr == 8'h14) begin
                {ofs, msync} <= bus_wdata[7:3];
            end
            age <= bus_we ? 5'h00 : age + {4'h0, !setl};
            gap <= sample_strobe ? 8'h01 : gap + 8'h01;
            gok <= !bus_we && (gok || (sample_strobe && setl));
            rok <= !bus_we && (rok || (sample_strobe && setl));
            oage <= $rose(data_rate_clock_out) ? 8'h01 : oage + 8'h01;
            if (sample_strobe) rel <= oage;
            pin_q <= data_rate_clock_in;
            eage <= (data_rate_clock_in != pin_q && data_rate_clock_in == pol)
                ? 4'h1 : eage + {3'h0, eage != 4'hf};
        end
    end
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_rd(a);
        bus_re && bus_addr == a;
    endsequence
    AST_RD_IDLE: assert property (!bus_re |=> bus_rdata == 8'h00)
        else $error("read data not idle");
    AST_RD_FAC: assert property (s_rd(8'h04) |=> bus_rdata ==
        {6'h00, $past(fac)}) else $error("factor readback wrong");
    AST_RD_CTRL: assert property (s_rd(8'h08) |=> bus_rdata ==
        {3'h0, $past(pol), $past(dcoe), $past(rec), 2'h0})
        else $error("control readback wrong");
    AST_RD_SYNC: assert property (s_rd(8'h14) |=> bus_rdata ==
        {$past(ofs), $past(msync), 3'h0}) else $error("offset readback");
    AST_OE_MODE: assert property (setl |-> data_rate_clock_oe == dcoe)
        else $error("pin drive does not follow mode");
    AST_OUT_IDLE: assert property (setl && !dcoe |-> !data_rate_clock_out)
        else $error("clock output active outside master");
    AST_GAP: assert property (paced && setl && gok && sample_strobe
        |-> gap == nfac) else $error("capture spacing wrong");
    AST_PIN_EDGE: assert property (pinm && setl && sample_strobe
        |-> eage >= 4'h2 && eage <= 4'h5) else $error("pin edge capture");
    AST_REL: assert property (dcoe && fac != 2'h0 && setl && rok
        && sample_strobe |-> oage == rel) else $error("clock and capture apart");
    AST_HOLD: assert property (!sample_strobe |-> $stable(sample_out))
        else $error("sample changed without capture");
endmodule
bind dlp_data_port dlp_port_props #(.W(W)) u_props (
    .clk(clk), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
    .bus_rdata(bus_rdata), .data_rate_clock_in(data_rate_clock_in),
    .data_rate_clock_out(data_rate_clock_out),
    .data_rate_clock_oe(data_rate_clock_oe), .sample_in(sample_in),
    .sample_out(sample_out), .sample_strobe(sample_strobe),
    .dac_code(dac_code)
);

// >>> dlp_source.sv
// Data source model: data-rate clock and sample pins.
`timescale 1ns/10ps
module dlp_source (
    input wire run, // Let the pin clock toggle
    input wire launch_rise, // Change data on the rising pin edge
    output reg pin_clk, // Data-rate clock pin
    output reg [15:0] data // Sample pins
);
    // Pin clock of 160 ns, offset from the conversion clock
    initial begin
        pin_clk = 1'b0;
        data = 16'h0000;
        #3;
        forever begin
            #80;
            if (run) pin_clk = ~pin_clk;
        end
    end
    // New sample on the edge away from the capture edge
    always @(pin_clk) begin
        if (pin_clk == launch_rise) data <= data + 16'h0001;
    end
endmodule

// >>> testbench.sv
// Self-checking bench for the sample port.
`timescale 1ns/10ps
module testbench;
    reg clk, arst_n, bus_we, bus_re, src_run, src_rise;
    reg [7:0] bus_addr, bus_wdata;
    wire [7:0] bus_rdata;
    wire pin, clk_out, clk_oe, strobe;
    wire [15:0] s_in, s_out, code;
    wire pin_lvl = clk_oe ? clk_out : pin;
    integer miscompares, checks_done, cyc, f, p0, p1, p2;
    dlp_data_port #(.W(16)) dut (.clk(clk), .arst_n(arst_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
        .bus_re(bus_re), .bus_rdata(bus_rdata),
        .data_rate_clock_in(pin_lvl), .data_rate_clock_out(clk_out),
        .data_rate_clock_oe(clk_oe), .sample_in(s_in), .sample_out(s_out),
        .sample_strobe(strobe), .dac_code(code));
    dlp_source src (.run(src_run), .launch_rise(src_rise), .pin_clk(pin),
        .data(s_in));
    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task check(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            bus_addr <= a;
            bus_wdata <= d;
            bus_we <= 1'b1;
            @(posedge clk);
            bus_we <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp, input [7:0] m);
        begin
            @(posedge clk);
            bus_addr <= a;
            bus_re <= 1'b1;
            @(posedge clk);
            bus_re <= 1'b0;
            #1;
            check({8'h00, bus_rdata & m}, {8'h00, exp});
        end
    endtask
    task mode_chk(input [7:0] c, input [7:0] s, input [2:0] m);
        begin
            wr(8'h08, c);
            wr(8'h14, s);
            rd(8'h08, c, 8'hff);
            rd(8'h14, s, 8'hff);
            rd(8'h40, {m, 5'h00}, 8'he0);
        end
    endtask
    // Position, modulo n, of the next capture or generated clock rise
    task spos(input sel, input integer n, output integer p);
        integer k;
        begin
            repeat (40) @(posedge clk);
            #1;
            k = 0;
            while (sel && clk_out !== 1'b0 && k < 20) begin
                @(posedge clk);
                #1;
                k = k + 1;
            end
            while ((sel ? clk_out : strobe) !== 1'b1 && k < 40) begin
                @(posedge clk);
                #1;
                k = k + 1;
            end
            p = cyc % n;
        end
    endtask
    task t_ofs(input [1:0] fs, input [3:0] c, input integer sh);
        integer n, a0, b0, a, b;
        begin
            n = 1 << fs;
            wr(8'h04, {6'h00, fs});
            wr(8'h14, 8'h00);
            spos(0, n, a0);
            spos(1, n, b0);
            wr(8'h14, {c, 4'h0});
            spos(0, n, a);
            spos(1, n, b);
            check(a, (a0 + sh + n) % n);
            check(b, (b0 + sh + n) % n);
        end
    endtask
    task t_pin(input pl);
        integer k, cnt;
        reg [15:0] last;
        begin
            src_rise <= ~pl;
            wr(8'h08, {3'h0, pl, 4'h0});
            repeat (40) @(posedge clk);
            #1;
            cnt = 0;
            last = s_out;
            for (k = 0; k < 64; k = k + 1) begin
                @(posedge clk);
                #1;
                if (strobe === 1'b1) begin
                    check(s_out, last + 16'h0001);
                    last = s_out;
                    cnt = cnt + 1;
                end
            end
            check(cnt, 8);
        end
    endtask
    task t_regs;
        begin
            rd(8'h04, 8'h00, 8'hff);
            rd(8'h14, 8'h00, 8'hff);
            rd(8'h3c, 8'h00, 8'hff);
            rd(8'h41, 8'h00, 8'hff);
            mode_chk(8'h00, 8'h00, 3'h1);
            mode_chk(8'h08, 8'h00, 3'h0);
            mode_chk(8'h04, 8'h00, 3'h2);
            mode_chk(8'h00, 8'h08, 3'h3);
            mode_chk(8'h04, 8'h08, 3'h4);
            $display("register test done");
        end
    endtask
    task t_ext;
        begin
            mode_chk(8'h00, 8'h00, 3'h1);
            for (f = 0; f < 4; f = f + 1) begin
                wr(8'h04, f[7:0]);
                rd(8'h04, f[7:0], 8'hff);
                wr(8'h08, 8'h10);
                spos(0, 1 << f, p1);
                wr(8'h08, 8'h00);
                spos(0, 1 << f, p0);
                check((p1 - p0 + (1 << f)) % (1 << f), (1 << f) / 2);
                wr(8'h14, 8'h70);
                spos(0, 1 << f, p2);
                check(p2, p0);
                check({15'h0000, clk_oe}, 16'h0000);
                wr(8'h14, 8'h00);
            end
            $display("external sync test done");
        end
    endtask
    // Source stopped: capture, readback and output code all show its word
    task t_sample;
        begin
            repeat (20) @(posedge clk);
            #1;
            check(s_out, s_in);
            check(code, s_in);
            rd(8'h44, s_in[7:0], 8'hff);
            rd(8'h48, s_in[15:8], 8'hff);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        #200000;
        miscompares = miscompares + 1;
        finish_test;
    end
    // Main sequence
    initial begin
        {arst_n, bus_we, bus_re, src_rise} = 4'h0;
        {bus_addr, bus_wdata} = 16'h0000;
        {miscompares, checks_done, cyc} = 96'h0;
        src_run = 1'b1;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_regs;
        t_ext;
        src_run <= 1'b0;
        wr(8'h08, 8'h18);
        t_ofs(2'h3, 4'hf, -1);
        t_ofs(2'h3, 4'h1, 1);
        t_ofs(2'h3, 4'h8, 0);
        t_ofs(2'h2, 4'h1, 0);
        t_ofs(2'h2, 4'h2, 1);
        t_ofs(2'h2, 4'h8, -4);
        t_ofs(2'h1, 4'h4, 1);
        t_ofs(2'h1, 4'h8, -2);
        t_ofs(2'h1, 4'h3, 0);
        t_sample;
        $display("master offset test done");
        src_run <= 1'b1;
        wr(8'h14, 8'h08);
        t_pin(1'b1);
        t_pin(1'b0);
        $display("pin capture test done");
        finish_test;
    end
endmodule
